// ### logic/aifd_decoder.sv
// Instruction field decoder between the code store and the control unit
`timescale 1ns/1ps
`include "aifd_params.svh"
// What this block does
// [RULE1] Takes one 32-bit instruction word per instruction and splits it by operation code.
// [RULE2] Flags an error for any bit pattern that is no valid instruction.
// [RULE3] Operation field yields write enables, broadcast, ALU function, jump, loop, array controls.
// [RULE4] Top four operation bits give one of fifteen functional groups; code 15 is invalid.
// [RULE5] Primary selector names register 0 to 13, or edge register where allowed.
// [RULE6] Scalar ops: primary register is first operand and destination; edge only some shifts.
// [RULE7] Primary selector also names broadcast, bit-test or response register.
// [RULE8] Array ops: modifier picks register 1 to 7, or code for no modification.
// [RULE9] Loop and jump ops: modifier picks register 1 to 13, or no modification.
// [RULE10] Scalar ops: modifier picks register 0 to 13 as second operand.
// [RULE11] Plane address field is eight bits of bit-plane address.
// [RULE12] Integer field is 5 bits on small machine, 6 bits on large.
// [RULE13] Word-select bit absent on small machine, one bit on large.
// [RULE14] Loop step control leaves, increments or decrements the address.
// [RULE15] Step type picks plane address or row/column address for stepping.
// [RULE16] Direction bit sets shift direction or carry propagation direction.
// [RULE17] Topology bit picks planar zero-fill or cyclic wrap edges.
// [RULE18] Sixteen-bit literal is zero-extended to 32 bits.
// [RULE19] Jump target field covers every location of the program block.
// [RULE20] Compound instruction issues first component, then second.
// [RULE21] Sums without carry destination discard the carry.
// [RULE22] Inverted operand flag complements every plane bit before use.
// [RULE23] Broadcast is row form or orthogonal column form.
// [RULE24] Decoded fields appear the cycle after the word is registered.
module aifd_decoder import aifd_pkg::*; #(
  parameter int INT_W  = 6,
  parameter int WORD_W = 1
) (
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  input  wire logic                     instr_valid_i,
  input  wire logic [`AIFD_INSTR_W-1:0] instr_word_i,
  input  wire logic                     err_clear_i,
  output logic                          instr_ready_o,
  output logic                          dec_valid_o,
  output aifd_dec_s                     dec_o,
  output logic                          invalid_o,
  output logic                          err_flag_o
);
  // ------------------------
  // State
  // ------------------------
  localparam logic [`AIFD_INT_MAX_W-1:0] INT_MASK = `AIFD_INT_MAX_W'((1 << INT_W) - 1);

  logic [`AIFD_INSTR_W-1:0] instr;
  logic [`AIFD_INSTR_W-1:0] next_instr;
  logic                     held;
  logic                     next_held;
  aifd_state_e              state;
  aifd_state_e              next_state;
  aifd_dec_s                next_dec;
  logic                     next_dec_valid;
  logic                     next_invalid;
  logic                     next_err_flag;
  aifd_dec_s                d;
  logic                     illegal;
  logic                     accept;
  logic [3:0]               grp;
  logic [1:0]               sub;

  aifd_legality #(
    .INT_W  (INT_W),
    .WORD_W (WORD_W)
  ) u_legality (
    .instr_i   (instr),
    .invalid_o (illegal)
  );

  // ------------------------
  // Field decode of the held word
  // ------------------------
  always_comb begin
    grp = instr[`AIFD_GRP_HI:`AIFD_GRP_LO]; // [RULE4]
    sub = instr[`AIFD_SUB_HI:`AIFD_SUB_LO];
    d = '0;
    d.group = aifd_group_e'(grp); // [RULE4]
    d.subop = sub;
    d.primary_reg_select   = instr[`AIFD_PRI_HI:`AIFD_PRI_LO]; // [RULE5]
    d.primary_is_edge_reg  = (d.primary_reg_select == `AIFD_REG_EDGE); // [RULE7]
    d.modifier_reg_select  = instr[`AIFD_MOD_HI:`AIFD_MOD_LO];
    d.modifier_is_edge_reg = (d.modifier_reg_select == `AIFD_REG_EDGE);
    d.is_array = aifd_is_array(grp);
    d.compound = aifd_compound(grp, sub);
    if (d.is_array) begin
      d.modifier_none = (d.modifier_reg_select == `AIFD_MOD_NONE); // [RULE8]
      d.plane_addr = instr[`AIFD_ADDR_HI:`AIFD_ADDR_LO]; // [RULE11]
      d.int_field  = instr[`AIFD_INT_HI:`AIFD_INT_LO] & INT_MASK; // [RULE12]
      d.word_sel   = (WORD_W != 0) ? instr[`AIFD_WORD_BIT] : 1'b0; // [RULE13]
      d.loop_step_control = aifd_step_e'(instr[`AIFD_STEP_HI:`AIFD_STEP_LO]); // [RULE14]
    end
    case (d.group)
      AIFD_G_STORE: begin
        d.store_read = 1'b1;
        d.pe_clock = 1'b1;
        d.step_rowcol = instr[`AIFD_STYPE_BIT]; // [RULE15]
        case (sub)
          2'h0: d.dest_a = 1'b1;
          2'h1: begin
            d.dest_a = 1'b1;
            d.and_with_dest = 1'b1;
          end
          2'h2: d.dest_a = 1'b1;
          default: begin
            d.dest_q = 1'b1;
            d.carry_discard = 1'b1; // [RULE21]
          end
        endcase
      end
      AIFD_G_EQUIV: begin
        d.store_read = 1'b1;
        d.pe_clock = 1'b1;
        d.invert = instr[`AIFD_STYPE_BIT]; // [RULE22]
        d.dest_a = (sub != 2'h2);
        d.dest_q = (sub == 2'h2);
        d.and_with_dest = (sub == 2'h1);
      end
      AIFD_G_LOADREG: begin
        d.store_read = 1'b1;
        d.reg_write = 1'b1; // [RULE3]
        d.response = 1'b1; // [RULE7]
        d.step_rowcol = instr[`AIFD_STYPE_BIT]; // [RULE15]
        case (sub)
          2'h0: d.scope = AIFD_SC_ROW;
          2'h1: d.scope = AIFD_SC_COLUMN;
          2'h2: d.scope = AIFD_SC_WORD;
          default: d.scope = AIFD_SC_PLANE;
        endcase
      end
      AIFD_G_ORTHBC, AIFD_G_ROWBC: begin
        d.array_broadcast = 1'b1; // [RULE23]
        d.orth_broadcast = (d.group == AIFD_G_ORTHBC); // [RULE23]
        d.pe_clock = 1'b1;
        d.invert = instr[`AIFD_STYPE_BIT]; // [RULE22]
        d.dest_a = (sub <= 2'h1);
        d.dest_q = (sub >= 2'h2);
        d.and_with_dest = (sub == 2'h1);
        d.carry_discard = (sub == 2'h3); // [RULE21]
      end
      AIFD_G_CONST: begin
        case (sub)
          2'h0: begin
            d.dest_a = 1'b1;
            d.zero_operand = 1'b1;
            d.pe_clock = 1'b1;
          end
          2'h1: begin
            d.dest_q = 1'b1;
            d.ones_operand = 1'b1;
            d.pe_clock = 1'b1;
          end
          2'h2: begin
            d.store_write = 1'b1; // [RULE3]
            d.zero_operand = 1'b1;
          end
          default: begin
            d.dest_q = 1'b1;
            d.zero_operand = 1'b1;
            d.pe_clock = 1'b1;
          end
        endcase
      end
      AIFD_G_BITBC: begin
        d.array_broadcast = 1'b1;
        d.pe_clock = 1'b1;
        d.invert = instr[`AIFD_STYPE_BIT]; // [RULE22]
        d.dest_a = (sub != 2'h2);
        d.dest_q = (sub == 2'h2);
        d.and_with_dest = (sub == 2'h1);
      end
      AIFD_G_STOREBC: begin
        d.array_broadcast = 1'b1; // [RULE23]
        d.store_write = 1'b1;
        d.step_rowcol = instr[`AIFD_STYPE_BIT]; // [RULE15]
        d.scope = (sub == 2'h0) ? AIFD_SC_PLANE : (sub == 2'h1) ? AIFD_SC_ROW : AIFD_SC_WORD;
      end
      AIFD_G_SHIFT: begin
        d.pe_clock = 1'b1;
        // Direction and topology overlay the plane address, which shifts do not use
        d.plane_addr = '0;
        d.shift_right = instr[`AIFD_DIR_BIT]; // [RULE16]
        d.edge_topology_select = instr[`AIFD_GEOM_BIT]; // [RULE17]
        d.dest_a = (sub == 2'h0);
        d.dest_q = (sub != 2'h0);
        d.carry_discard = (sub == 2'h2); // [RULE21]
      end
      AIFD_G_SREG, AIFD_G_SLIT: begin
        d.is_scalar = 1'b1;
        d.reg_write = 1'b1; // [RULE6]
        d.use_literal = (d.group == AIFD_G_SLIT);
        if (d.group == AIFD_G_SLIT) begin
          d.modifier_reg_select = '0;
          d.modifier_is_edge_reg = 1'b0;
          d.literal = {{(`AIFD_DATA_W - `AIFD_LIT_W){1'b0}},
                       instr[`AIFD_LIT_HI:`AIFD_LIT_LO]}; // [RULE18]
        end
        case (sub)
          2'h0: d.alu = AIFD_ALU_ADD; // [RULE10]
          2'h1: d.alu = AIFD_ALU_SUB;
          2'h2: d.alu = AIFD_ALU_AND;
          default: d.alu = AIFD_ALU_OR;
        endcase
      end
      AIFD_G_SSHIFT: begin
        d.is_scalar = 1'b1;
        d.reg_write = 1'b1; // [RULE6]
        d.int_field = instr[`AIFD_INT_HI:`AIFD_INT_LO] & INT_MASK; // [RULE12]
        d.alu = (sub == 2'h0) ? AIFD_ALU_SHL : (sub == 2'h1) ? AIFD_ALU_SHR : AIFD_ALU_ROT;
      end
      AIFD_G_JUMP, AIFD_G_JEDGE, AIFD_G_LOOP: begin
        d.modifier_none = (d.modifier_reg_select == `AIFD_MOD_NONE); // [RULE9]
        d.jump_target = instr[`AIFD_JMP_HI:`AIFD_JMP_LO]; // [RULE19]
        d.is_jump = (d.group == AIFD_G_JUMP) || (d.group == AIFD_G_JEDGE && sub == 2'h0);
        d.jump_on_edge_instr = (d.group == AIFD_G_JEDGE && sub == 2'h0);
        d.loop_exit = (d.group == AIFD_G_JEDGE && sub == 2'h1);
        d.is_loop = (d.group == AIFD_G_LOOP); // [RULE3]
      end
      default: d.group = AIFD_G_NONE;
    endcase
    // Second half of load_a_clear_c_compound and of the Q/C zero pair: clear C only
    if (d.compound && state == AIFD_S_SECOND) begin
      d.second = 1'b1; // [RULE20]
      d.store_read = 1'b0;
      d.dest_a = 1'b0;
      d.dest_q = 1'b0;
      d.dest_c = 1'b1;
      d.zero_operand = 1'b1;
      d.and_with_dest = 1'b0;
      d.loop_step_control = AIFD_ST_HOLD;
    end
    // A bad word clears every write, read, clock and branch enable and array_broadcast, but not orth_broadcast, jump_on_edge_instr or loop_step_control
    if (illegal) begin
      d.reg_write = 1'b0; // [RULE2]
      d.store_write = 1'b0;
      d.store_read = 1'b0;
      d.pe_clock = 1'b0;
      d.dest_a = 1'b0;
      d.dest_q = 1'b0;
      d.dest_c = 1'b0;
      d.response = 1'b0;
      d.array_broadcast = 1'b0;
      d.is_jump = 1'b0;
      d.is_loop = 1'b0;
      d.loop_exit = 1'b0;
      d.compound = 1'b0;
    end
  end

  // ------------------------
  // Fetch and issue sequencing
  // ------------------------
  // The code store is stalled only while the first half of a compound issues
  assign instr_ready_o = !(held && d.compound && state == AIFD_S_RUN); // [RULE20]
  assign accept = instr_valid_i && instr_ready_o;

  always_comb begin
    next_instr = accept ? instr_word_i : instr; // [RULE1]
    next_state = AIFD_S_RUN;
    next_held = accept;
    next_dec = dec_o;
    next_dec_valid = 1'b0;
    next_invalid = 1'b0;
    next_err_flag = err_flag_o && !err_clear_i;
    case (state)
      AIFD_S_RUN: begin
        if (held) begin
          next_dec = d; // [RULE24]
          next_dec_valid = 1'b1;
          next_invalid = illegal;
          if (d.compound) begin
            next_state = AIFD_S_SECOND; // [RULE20]
            next_held = 1'b1;
          end
        end
      end
      AIFD_S_SECOND: begin
        next_dec = d; // [RULE20]
        next_dec_valid = 1'b1;
      end
      default: next_state = AIFD_S_RUN;
    endcase
    // A new error in the clearing cycle wins over the clear
    if (next_invalid) begin
      next_err_flag = 1'b1; // [RULE2]
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      instr       <= `AIFD_RST_WORD;
      held        <= 1'b0;
      state       <= AIFD_S_RUN;
      dec_o       <= '0;
      dec_valid_o <= 1'b0;
      invalid_o   <= 1'b0;
      err_flag_o  <= 1'b0;
    end else begin
      instr       <= next_instr;
      held        <= next_held;
      state       <= next_state;
      dec_o       <= next_dec;
      dec_valid_o <= next_dec_valid;
      invalid_o   <= next_invalid;
      err_flag_o  <= next_err_flag;
    end
  end
endmodule // aifd_decoder

// ### logic/aifd_params.svh
// Field positions, codes and reset values of the array instruction field decoder
`ifndef AIFD_PARAMS_SVH
`define AIFD_PARAMS_SVH

// ------------------------
// Word and operand widths
// ------------------------
`define AIFD_INSTR_W     32
`define AIFD_DATA_W      32
`define AIFD_LIT_W       16
`define AIFD_ADDR_W      8
`define AIFD_INT_MAX_W   6
`define AIFD_JMP_W       15

// ------------------------
// Field positions
// ------------------------
`define AIFD_GRP_HI      31
`define AIFD_GRP_LO      28
`define AIFD_SUB_HI      27
`define AIFD_SUB_LO      26
`define AIFD_STEP_HI     25
`define AIFD_STEP_LO     24
`define AIFD_STYPE_BIT   23
`define AIFD_PRI_HI      22
`define AIFD_PRI_LO      19
`define AIFD_MOD_HI      18
`define AIFD_MOD_LO      15
`define AIFD_ADDR_HI     14
`define AIFD_ADDR_LO     7
`define AIFD_WORD_BIT    6
`define AIFD_INT_HI      5
`define AIFD_INT_LO      0
`define AIFD_DIR_BIT     14
`define AIFD_GEOM_BIT    13
`define AIFD_LIT_HI      15
`define AIFD_LIT_LO      0
`define AIFD_LSPARE_HI   18
`define AIFD_LSPARE_LO   16
`define AIFD_JMP_HI      14
`define AIFD_JMP_LO      0

// ------------------------
// Register selector codes
// ------------------------
`define AIFD_REG_MAX     4'hd
`define AIFD_REG_EDGE    4'he
`define AIFD_REG_BAD     4'hf
`define AIFD_MOD_NONE    4'h0
`define AIFD_AMOD_MAX    4'h7

// ------------------------
// Reset values
// ------------------------
`define AIFD_RST_WORD    32'h00000000

`endif

// ### logic/aifd_pkg.sv
// Types and shared decode helpers of the array instruction field decoder
package aifd_pkg;
  `include "aifd_params.svh"

  // ------------------------
  // Enumerations
  // ------------------------
  typedef enum logic [3:0] {
    AIFD_G_STORE   = 4'h0, AIFD_G_EQUIV  = 4'h1, AIFD_G_LOADREG = 4'h2,
    AIFD_G_ORTHBC  = 4'h3, AIFD_G_CONST  = 4'h4, AIFD_G_BITBC   = 4'h5,
    AIFD_G_STOREBC = 4'h6, AIFD_G_ROWBC  = 4'h7, AIFD_G_SHIFT   = 4'h8,
    AIFD_G_SREG    = 4'h9, AIFD_G_SLIT   = 4'ha, AIFD_G_SSHIFT  = 4'hb,
    AIFD_G_JUMP    = 4'hc, AIFD_G_JEDGE  = 4'hd, AIFD_G_LOOP    = 4'he,
    AIFD_G_NONE    = 4'hf
  } aifd_group_e;

  typedef enum logic [1:0] {
    AIFD_SC_PLANE = 2'h0, AIFD_SC_ROW = 2'h1, AIFD_SC_COLUMN = 2'h2, AIFD_SC_WORD = 2'h3
  } aifd_scope_e;

  typedef enum logic [1:0] {
    AIFD_ST_HOLD = 2'h0, AIFD_ST_INC = 2'h1, AIFD_ST_DEC = 2'h2, AIFD_ST_BAD = 2'h3
  } aifd_step_e;

  typedef enum logic [2:0] {
    AIFD_ALU_NONE = 3'h0, AIFD_ALU_ADD = 3'h1, AIFD_ALU_SUB = 3'h2, AIFD_ALU_AND = 3'h3,
    AIFD_ALU_OR   = 3'h4, AIFD_ALU_SHL = 3'h5, AIFD_ALU_SHR = 3'h6, AIFD_ALU_ROT = 3'h7
  } aifd_alu_e;

  typedef enum logic [1:0] {
    AIFD_S_RUN = 2'b01, AIFD_S_SECOND = 2'b10
  } aifd_state_e;

  // ------------------------
  // Decoded instruction
  // ------------------------
  typedef struct packed {
    aifd_group_e              group;
    logic [1:0]               subop;
    logic                     is_array;
    logic                     is_scalar;
    logic                     is_jump;
    logic                     is_loop;
    logic                     loop_exit;
    logic                     jump_on_edge_instr;
    logic                     reg_write;
    logic                     array_broadcast;
    logic                     orth_broadcast;
    logic                     store_read;
    logic                     store_write;
    logic                     pe_clock;
    logic                     dest_a;
    logic                     dest_q;
    logic                     dest_c;
    logic                     and_with_dest;
    logic                     zero_operand;
    logic                     ones_operand;
    logic                     response;
    aifd_scope_e              scope;
    aifd_alu_e                alu;
    logic [3:0]               primary_reg_select;
    logic                     primary_is_edge_reg;
    logic [3:0]               modifier_reg_select;
    logic                     modifier_is_edge_reg;
    logic                     modifier_none;
    logic [`AIFD_ADDR_W-1:0]  plane_addr;
    logic [`AIFD_INT_MAX_W-1:0] int_field;
    logic                     word_sel;
    aifd_step_e               loop_step_control;
    logic                     step_rowcol;
    logic                     shift_right;
    logic                     edge_topology_select;
    logic                     use_literal;
    logic [`AIFD_DATA_W-1:0]  literal;
    logic [`AIFD_JMP_W-1:0]   jump_target;
    logic                     invert;
    logic                     carry_discard;
    logic                     compound;
    logic                     second;
  } aifd_dec_s;

  // ------------------------
  // Shared helpers
  // ------------------------
  function automatic logic aifd_is_array(input logic [3:0] g);
    aifd_is_array = (g <= 4'h8);
  endfunction

  // Groups whose primary selector may name the edge register
  function automatic logic aifd_pri_edge_ok(input logic [3:0] g, input logic [1:0] s);
    case (g)
      4'h1, 4'h3, 4'h5, 4'h6, 4'h7: aifd_pri_edge_ok = 1'b1;
      4'h2:                         aifd_pri_edge_ok = (s != 2'h2);
      4'hb:                         aifd_pri_edge_ok = (s <= 2'h1);
      default:                      aifd_pri_edge_ok = 1'b0;
    endcase
  endfunction

  function automatic logic aifd_compound(input logic [3:0] g, input logic [1:0] s);
    aifd_compound = (s == 2'h2 && g == 4'h0) || (s == 2'h3 && g == 4'h4);
  endfunction
endpackage

// ### logic/aifd_legality.sv
// Bit-pattern legality check of one instruction word
`timescale 1ns/1ps
`include "aifd_params.svh"
module aifd_legality import aifd_pkg::*; #(
  parameter int INT_W  = 6,
  parameter int WORD_W = 1
) (
  input  wire logic [`AIFD_INSTR_W-1:0] instr_i,
  output logic                          invalid_o
);
  logic [3:0] grp;
  logic [1:0] sub;
  logic [3:0] pri;
  logic [3:0] md;
  logic       bad;

  always_comb begin
    grp = instr_i[`AIFD_GRP_HI:`AIFD_GRP_LO];
    sub = instr_i[`AIFD_SUB_HI:`AIFD_SUB_LO];
    pri = instr_i[`AIFD_PRI_HI:`AIFD_PRI_LO];
    md  = instr_i[`AIFD_MOD_HI:`AIFD_MOD_LO];
    bad = (grp == 4'hf);
    bad = bad || (pri == `AIFD_REG_BAD);
    bad = bad || (pri == `AIFD_REG_EDGE && !aifd_pri_edge_ok(grp, sub)); // [RULE5]
    case (grp)
      4'h1, 4'h5, 4'h6, 4'h8, 4'hb: bad = bad || (sub == 2'h3);
      4'hd:                         bad = bad || (sub > 2'h1);
      default:                      bad = bad;
    endcase
    if (aifd_is_array(grp)) begin
      bad = bad || (md > `AIFD_AMOD_MAX); // [RULE8]
      bad = bad || (instr_i[`AIFD_STEP_HI:`AIFD_STEP_LO] == 2'h3); // [RULE14]
      // Narrow machines carry no word bit and a shorter integer field
      bad = bad || (WORD_W == 0 && instr_i[`AIFD_WORD_BIT]); // [RULE13]
      bad = bad || (INT_W < `AIFD_INT_MAX_W && instr_i[`AIFD_INT_HI]); // [RULE12]
    end
    if (grp >= 4'hc && grp <= 4'he) begin
      bad = bad || (md > `AIFD_REG_MAX); // [RULE9]
    end
    if (grp == 4'h9 || grp == 4'hb) begin
      bad = bad || (md == `AIFD_REG_BAD); // [RULE10]
      bad = bad || (md == `AIFD_REG_EDGE && !(grp == 4'hb && sub <= 2'h1)); // [RULE6]
    end
    if (grp == 4'hb) begin
      bad = bad || (INT_W < `AIFD_INT_MAX_W && instr_i[`AIFD_INT_HI]);
    end
    if (grp == 4'ha) begin
      bad = bad || (instr_i[`AIFD_LSPARE_HI:`AIFD_LSPARE_LO] != 3'h0);
    end
    invalid_o = bad; // [RULE2]
  end
endmodule // aifd_legality

// ### verif/aifd_decoder_props.sv
// Port-level assertions of the instruction field decoder
`timescale 1ns/1ps
`include "aifd_params.svh"
module aifd_decoder_props import aifd_pkg::*; #(
  parameter int INT_W  = 6,
  parameter int WORD_W = 1
) (
  input wire logic                     clock_i,
  input wire logic                     rst_i,
  input wire logic                     instr_valid_i,
  input wire logic [`AIFD_INSTR_W-1:0] instr_word_i,
  input wire logic                     err_clear_i,
  input wire logic                     instr_ready_o,
  input wire logic                     dec_valid_o,
  input wire aifd_dec_s                dec_o,
  input wire logic                     invalid_o,
  input wire logic                     err_flag_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic ok;
  assign take = instr_valid_i && instr_ready_o;
  // Plain issues only: a compound's second half decodes an older word
  assign ok = dec_valid_o && !invalid_o && !dec_o.second;
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  sequence s_first; !instr_ready_o ##1 (dec_valid_o && !dec_o.second); endsequence
  sequence s_second; dec_valid_o && dec_o.second && dec_o.dest_c && dec_o.zero_operand; endsequence
  property p_answer; take |-> ##2 dec_valid_o; endproperty
  property p_compound;
    take && (instr_word_i[31:26] == 6'h02 || instr_word_i[31:26] == 6'h13) |-> ##1 s_first ##1 s_second;
  endproperty
  property p_illegal; take && instr_word_i[31:28] == 4'hf |-> ##2 invalid_o && err_flag_o; endproperty
  property p_group; ok |-> dec_o.group == $past(instr_word_i[31:28], 2); endproperty
  property p_literal;
    ok && dec_o.group == AIFD_G_SLIT |-> dec_o.literal == {16'h0, $past(instr_word_i[15:0], 2)};
  endproperty
  property p_jump; ok && dec_o.group == AIFD_G_JUMP |-> dec_o.jump_target == $past(instr_word_i[14:0], 2); endproperty
  property p_shift;
    ok && dec_o.group == AIFD_G_SHIFT |-> dec_o.shift_right == $past(instr_word_i[14], 2)
      && dec_o.edge_topology_select == $past(instr_word_i[13], 2);
  endproperty
  property p_inv; invalid_o |-> dec_valid_o && err_flag_o && !dec_o.reg_write; endproperty
  property p_sticky; err_flag_o && !err_clear_i |=> err_flag_o; endproperty
  property p_clear; err_clear_i |=> err_flag_o == invalid_o; endproperty
  a_answer: assert property (p_answer) else $error("no decode two cycles after take");
  a_compound: assert property (p_compound) else $error("compound issue order wrong");
  a_illegal: assert property (p_illegal) else $error("illegal group not flagged");
  a_group: assert property (p_group) else $error("group field wrong");
  a_literal: assert property (p_literal) else $error("literal not zero extended");
  a_jump: assert property (p_jump) else $error("jump target wrong");
  a_shift: assert property (p_shift) else $error("shift direction or topology wrong");
  a_inv: assert property (p_inv) else $error("invalid pulse without error state");
  a_sticky: assert property (p_sticky) else $error("error flag dropped");
  a_clear: assert property (p_clear) else $error("error flag not cleared");
endmodule // aifd_decoder_props

// ### verif/aifd_code_store.sv
// Behavioural code store that offers queued instruction words
`timescale 1ns/1ps
`include "aifd_params.svh"
module aifd_code_store import aifd_pkg::*; (
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  input  wire logic                     ready_i,
  output logic                          valid_o,
  output logic [`AIFD_INSTR_W-1:0]      word_o
);
  logic [`AIFD_INSTR_W-1:0] words [$];
  logic                     took = 1'b0;

  task automatic push(input logic [`AIFD_INSTR_W-1:0] w);
    words.push_back(w);
  endtask

  initial begin
    valid_o = 1'b0;
    word_o = '0;
  end
  // Ready only moves at edges, so mid-cycle is a race-free place to look
  always @(negedge clock_i) took = valid_o && ready_i && !rst_i;
  always @(posedge clock_i) begin
    if (took) void'(words.pop_front());
    #1;
    valid_o = words.size() > 0;
    // Idle bus keeps changing so a stale word never looks fresh
    word_o = valid_o ? words[0] : ~word_o;
  end
endmodule // aifd_code_store

// ### verif/tb_aifd_decoder.sv
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ps
`include "aifd_params.svh"
module tb_aifd_decoder import aifd_pkg::*;;
  logic                     clock_i = 1'b0;
  logic                     rst_i = 1'b1;
  logic                     err_clear_i = 1'b0;
  logic                     instr_valid_i;
  logic [`AIFD_INSTR_W-1:0] instr_word_i;
  logic                     instr_ready_o;
  logic                     dec_valid_o;
  aifd_dec_s                dec_o;
  logic                     invalid_o;
  logic                     err_flag_o;
  int                       n_errors = 0;
  int                       tests_run = 0;

  always #5 clock_i = ~clock_i;

  aifd_decoder #(.INT_W(6), .WORD_W(1)) u_aifd_decoder (.clock_i(clock_i), .rst_i(rst_i),
    .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .err_clear_i(err_clear_i),
    .instr_ready_o(instr_ready_o), .dec_valid_o(dec_valid_o), .dec_o(dec_o),
    .invalid_o(invalid_o), .err_flag_o(err_flag_o));
  aifd_code_store u_aifd_code_store (.clock_i(clock_i), .rst_i(rst_i),
    .ready_i(instr_ready_o), .valid_o(instr_valid_i), .word_o(instr_word_i));

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Hands one word to the store and returns in the cycle its decode shows
  task automatic issue(input logic [31:0] w);
    int n = 0;
    u_aifd_code_store.push(w);
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (dec_valid_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      print_verdict();
    end
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_groups();
    for (int i = 0; i < 16; i++) begin
      issue({i[3:0], 5'h0, 4'h1, 4'h1, 15'h0});
      chk(invalid_o, i == 15);
      if (i < 15) chk(dec_o.group, i);
      if (i < 15) chk(dec_o.is_array, i <= 8);
      if (i < 15) chk(dec_o.jump_on_edge_instr, i == 13);
    end
  endtask
  task automatic t_fields();
    for (int s = 0; s < 4; s++) begin
      issue({6'h0, s[1:0], 1'b1, 4'h2, 4'h7, 8'ha5, 1'b1, 6'h2a});
      chk(invalid_o, s == 3);
      if (s < 3) begin
        chk(dec_o.loop_step_control, s);
        chk(dec_o.step_rowcol, 1);
        chk(dec_o.plane_addr, 8'ha5);
        chk(dec_o.word_sel, 1);
        chk(dec_o.int_field, 6'h2a);
        chk(dec_o.modifier_reg_select, 4'h7);
      end
    end
  endtask
  task automatic t_scalar();
    issue({4'ha, 5'h0, 4'h3, 3'h0, 16'hfedc});
    chk(dec_o.literal, 32'h0000fedc);
    chk(dec_o.primary_reg_select, 4'h3);
    issue({4'hc, 9'h0, 4'hd, 15'h7fff});
    chk(dec_o.jump_target, 15'h7fff);
    chk(dec_o.modifier_reg_select, 4'hd);
    for (int d = 0; d < 2; d++) begin
      issue({4'h8, 13'h0, d[0], ~d[0], 13'h0});
      chk(dec_o.shift_right, d);
      chk(dec_o.edge_topology_select, !d);
    end
  endtask
  task automatic t_illegal();
    logic [31:0] bad [7] = '{32'hf000_0000, {9'h0, 4'hf, 19'h0}, {13'h0, 4'h8, 15'h0},
      {4'h1, 2'h3, 26'h0}, {4'hd, 2'h2, 26'h0}, {4'ha, 11'h0, 1'b1, 16'h0}, {4'h9, 5'h0, 4'he, 19'h0}};
    foreach (bad[i]) begin
      issue(bad[i]);
      chk({invalid_o, err_flag_o, dec_o.reg_write}, 3'b110);
    end
    issue({4'h7, 5'h0, 4'he, 19'h0});
    chk({invalid_o, dec_o.primary_is_edge_reg}, 2'b01);
    repeat (3) @(posedge clock_i);
    #1 chk(err_flag_o, 1);
    err_clear_i = 1'b1;
    @(posedge clock_i);
    #1 err_clear_i = 1'b0;
    chk(err_flag_o, 0);
  endtask
  task automatic t_compound();
    int k = 0;
    logic lo = 1'b0;
    u_aifd_code_store.push({4'h0, 2'h2, 3'h0, 4'h1, 4'h0, 8'h10, 7'h0});
    u_aifd_code_store.push({4'h4, 2'h3, 26'h0});
    for (int n = 0; n < 20 && k < 4; n++) begin
      @(posedge clock_i);
      #1 if (instr_ready_o === 1'b0) lo = 1'b1;
      if (dec_valid_o === 1'b1) begin
        chk(dec_o.second, k[0]);
        k++;
      end
    end
    chk({k[2:0], lo}, 4'h9);
  endtask

  initial begin
    repeat (12) @(posedge clock_i);
    #1 rst_i = 1'b0;
    t_groups();
    t_fields();
    t_scalar();
    t_illegal();
    t_compound();
    print_verdict();
  end
endmodule // tb_aifd_decoder

bind aifd_decoder aifd_decoder_props #(.INT_W(INT_W), .WORD_W(WORD_W)) u_aifd_decoder_props (
  .clock_i(clock_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i),
  .err_clear_i(err_clear_i), .instr_ready_o(instr_ready_o), .dec_valid_o(dec_valid_o),
  .dec_o(dec_o), .invalid_o(invalid_o), .err_flag_o(err_flag_o));
